// ---- src/pmi_pkg.sv ----
// Purpose: constants and types of the interrupt mask and acknowledge block
// Assumes: 8-bit register port driven by the serial slave on the same clock
// Notes:   offsets are the register addresses seen by the host
package pmi_pkg;
   localparam logic [7:0] PMI_SUPPLY_MASK_ADDR  = 8'h03;
   localparam logic [7:0] PMI_EVENT_MASK_ADDR   = 8'h04;
   localparam logic [7:0] PMI_SUPPLY_FLAGS_ADDR = 8'h05;
   localparam logic [7:0] PMI_EVENT_FLAGS_ADDR  = 8'h06;
   localparam logic [7:0] PMI_MASK_RESET        = 8'h00;
   localparam logic [7:0] PMI_FLAGS_RESET       = 8'h00;
   localparam logic [7:0] PMI_RDATA_UNMAPPED    = 8'h00;
   // event mask / flag bit positions
   localparam int PMI_CONV_DONE_BIT   = 7;
   localparam int PMI_HIZ_BIT         = 6;
   localparam int PMI_PIN2_EDGE_BIT   = 5;
   localparam int PMI_PIN1_EDGE_BIT   = 4;
   localparam int PMI_THERMAL_BIT     = 3;
   localparam int PMI_CHARGER_BIT     = 2;
   localparam int PMI_ABOVE_LIMIT_BIT = 1;
   localparam int PMI_BELOW_LIMIT_BIT = 0;

   typedef enum logic [1:0]
   {
      PMI_IDLE  = 2'b00,
      PMI_LATCH = 2'b01,
      PMI_HOLD  = 2'b11
   } pmi_state_e;

   typedef struct packed
   {
      pmi_state_e st;
      logic [7:0] mask1;
      logic [7:0] mask2;
      logic [7:0] flag1;
      logic [7:0] flag2;
      logic [7:0] prev1;
      logic [7:0] prev2;
      logic [7:0] rdata;
      logic       armed;
      logic       irq_n;
   } pmi_regs_s;
endpackage

// ---- src/pmi_irq_ctrl.sv ----
// Purpose: interrupt masking, flag latching and acknowledge handshake
// Assumes: status inputs are produced on clk_i; reg strobes mark only
//          completed host transfers, so an aborted transfer leaves no strobe
// Notes:   the line is low only in the hold state
`timescale 1ns/100ps
module pmi_irq_ctrl
   import pmi_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // monitored status levels
   input  wire logic [7:0] supply_fault_i,
   input  wire logic [7:0] event_status_i,
   // register port from serial slave
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   // interrupt line to host
   output logic            irq_n_o
);

   pmi_regs_s  r_q;
   pmi_regs_s  r_d;
   logic [7:0] hit1;
   logic [7:0] hit2;
   logic       ack_hit;
   logic       wr_sup_flags;
   logic       wr_evt_flags;

   always_comb
   begin
      r_d = r_q;
      // first cycle after reset only primes the history
      hit1 = r_q.armed ? ((supply_fault_i ^ r_q.prev1) & ~r_q.mask1)
                       : 8'h00;
      hit2 = r_q.armed ? ((event_status_i ^ r_q.prev2) & ~r_q.mask2)
                       : 8'h00;
      wr_sup_flags = reg_wr_i && (reg_addr_i == PMI_SUPPLY_FLAGS_ADDR);
      wr_evt_flags = reg_wr_i && (reg_addr_i == PMI_EVENT_FLAGS_ADDR);
      // a zero written over a set flag acknowledges
      ack_hit = (wr_sup_flags && ((r_q.flag1 & ~reg_wdata_i) != 8'h00)) ||
                (wr_evt_flags && ((r_q.flag2 & ~reg_wdata_i) != 8'h00));
      r_d.armed = 1'b1;
      // history tracks always, so changes during hold are simply lost
      r_d.prev1 = supply_fault_i;
      r_d.prev2 = event_status_i;
      if (reg_wr_i && reg_addr_i == PMI_SUPPLY_MASK_ADDR)
         r_d.mask1 = reg_wdata_i;
      if (reg_wr_i && reg_addr_i == PMI_EVENT_MASK_ADDR)
         r_d.mask2 = reg_wdata_i;
      // host can only clear flags; both flag registers AND in the written data
      if (r_q.st != PMI_LATCH && wr_sup_flags)
         r_d.flag1 = r_q.flag1 & reg_wdata_i;
      if (r_q.st != PMI_LATCH && wr_evt_flags)
         r_d.flag2 = r_q.flag2 & reg_wdata_i;
      case (r_q.st)
         PMI_IDLE:
         begin
            if ((hit1 | hit2) != 8'h00)
            begin
               r_d.flag1 = hit1;
               r_d.flag2 = hit2;
               r_d.st    = PMI_LATCH;
            end
         end
         PMI_LATCH: r_d.st = PMI_HOLD;
         PMI_HOLD:
         begin
            if (ack_hit)
               r_d.st = PMI_IDLE;
         end
         default: r_d.st = PMI_IDLE;
      endcase
      r_d.irq_n = (r_d.st != PMI_HOLD);
      case (reg_addr_i)
         PMI_SUPPLY_MASK_ADDR:  r_d.rdata = r_q.mask1;
         PMI_EVENT_MASK_ADDR:   r_d.rdata = r_q.mask2;
         PMI_SUPPLY_FLAGS_ADDR: r_d.rdata = r_q.flag1;
         PMI_EVENT_FLAGS_ADDR:  r_d.rdata = r_q.flag2;
         default:               r_d.rdata = PMI_RDATA_UNMAPPED;
      endcase
      if (!reg_rd_i)
         r_d.rdata = r_q.rdata;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         r_q.st    <= PMI_IDLE;
         r_q.mask1 <= PMI_MASK_RESET;
         r_q.mask2 <= PMI_MASK_RESET;
         r_q.flag1 <= PMI_FLAGS_RESET;
         r_q.flag2 <= PMI_FLAGS_RESET;
         r_q.prev1 <= 8'h00;
         r_q.prev2 <= 8'h00;
         r_q.rdata <= PMI_RDATA_UNMAPPED;
         r_q.armed <= 1'b0;
         r_q.irq_n <= 1'b1;
      end
      else
         r_q <= r_d;
   end

   assign reg_rdata_o = r_q.rdata;
   assign irq_n_o     = r_q.irq_n;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence raise_s;
      r_q.st == PMI_IDLE && (hit1 | hit2) != 8'h00;
   endsequence

   sequence line_low_s;
      ##1 (r_q.st == PMI_LATCH && irq_n_o) ##1 !irq_n_o;
   endsequence

   sequence ack_s;
      r_q.st == PMI_HOLD && ack_hit;
   endsequence

   // line stays high through the idle cycle and any latch cycle
   sequence stay_high_s;
      irq_n_o ##1 irq_n_o;
   endsequence

   supply_mask_a: assert property (
      r_q.st == PMI_IDLE && hit2 == 8'h00 &&
      (supply_fault_i ^ r_q.prev1) == r_q.mask1 && r_q.armed
      |=> r_q.st == PMI_IDLE)
      else $error("masked supply fault raised interrupt");

   supply_flag_a: assert property (
      r_q.armed && r_q.st == PMI_IDLE && !r_q.mask1[7] &&
      $changed(supply_fault_i[7]) |=> r_q.flag1[7])
      else $error("unmasked supply fault not flagged");

   supply_block_a: assert property ((hit1 & r_q.mask1) == 8'h00)
      else $error("masked supply fault passed");

   conv_mask_a: assert property (
      r_q.mask2[PMI_CONV_DONE_BIT] |-> !hit2[PMI_CONV_DONE_BIT])
      else $error("masked conversion done seen");

   conv_flag_a: assert property (
      r_q.armed && r_q.st == PMI_IDLE && !r_q.mask2[7] &&
      $changed(event_status_i[7]) |=> r_q.flag2[7])
      else $error("unmasked conversion done not flagged");

   hiz_mask_a: assert property (
      r_q.armed && !r_q.mask2[6] &&
      $changed(event_status_i[6]) && r_q.st == PMI_IDLE
      |=> r_q.flag2[6])
      else $error("unmasked high impedance not flagged");

   pin_mask_a: assert property (
      r_q.mask2[5] && r_q.mask2[4] |-> hit2[5:4] == 2'b00)
      else $error("masked pin edge passed");

   pin2_mask_a: assert property (
      r_q.mask2[PMI_PIN2_EDGE_BIT] |-> !hit2[PMI_PIN2_EDGE_BIT])
      else $error("masked pin two edge passed");

   pin1_mask_a: assert property (
      r_q.mask2[PMI_PIN1_EDGE_BIT] |-> !hit2[PMI_PIN1_EDGE_BIT])
      else $error("masked pin one edge passed");

   thermal_mask_a: assert property (
      r_q.mask2[PMI_THERMAL_BIT] && r_q.st == PMI_IDLE
      |=> !r_q.flag2[PMI_THERMAL_BIT] || r_q.st == PMI_IDLE)
      else $error("masked thermal fault flagged");

   charger_mask_a: assert property (
      r_q.mask2[PMI_CHARGER_BIT] |-> !hit2[PMI_CHARGER_BIT])
      else $error("masked charger change passed");

   limit_mask_a: assert property (
      r_q.mask2[1] && r_q.mask2[0] |-> hit2[1:0] == 2'b00)
      else $error("masked limit crossing passed");

   above_mask_a: assert property (
      r_q.mask2[PMI_ABOVE_LIMIT_BIT] |-> !hit2[PMI_ABOVE_LIMIT_BIT])
      else $error("masked above limit passed");

   below_mask_a: assert property (
      r_q.mask2[PMI_BELOW_LIMIT_BIT] |-> !hit2[PMI_BELOW_LIMIT_BIT])
      else $error("masked below limit passed");

   read_map_a: assert property (
      reg_rd_i && reg_addr_i == PMI_EVENT_MASK_ADDR
      |=> reg_rdata_o == $past(r_q.mask2))
      else $error("event mask readback wrong");

   read_sup_a: assert property (
      reg_rd_i && reg_addr_i == PMI_SUPPLY_MASK_ADDR
      |=> reg_rdata_o == $past(r_q.mask1))
      else $error("supply mask readback wrong");

   read_flag1_a: assert property (
      reg_rd_i && reg_addr_i == PMI_SUPPLY_FLAGS_ADDR
      |=> reg_rdata_o == $past(r_q.flag1))
      else $error("supply flags readback wrong");

   read_flag2_a: assert property (
      reg_rd_i && reg_addr_i == PMI_EVENT_FLAGS_ADDR
      |=> reg_rdata_o == $past(r_q.flag2))
      else $error("event flags readback wrong");

   read_unmapped_a: assert property (
      reg_rd_i && (reg_addr_i < PMI_SUPPLY_MASK_ADDR ||
      reg_addr_i > PMI_EVENT_FLAGS_ADDR)
      |=> reg_rdata_o == PMI_RDATA_UNMAPPED)
      else $error("unmapped read returned data");

   raise_order_a: assert property (raise_s |-> line_low_s)
      else $error("flags then line low order broken");

   hold_latch_a: assert property (
      r_q.st == PMI_HOLD && !reg_wr_i
      |=> $stable(r_q.flag1) && $stable(r_q.flag2) && !irq_n_o)
      else $error("flags changed while line low");

   latch_keep_a: assert property (
      r_q.st == PMI_LATCH
      |=> $stable(r_q.flag1) && $stable(r_q.flag2) && !irq_n_o)
      else $error("flags changed in latch cycle");

   ack_release_a: assert property (ack_s |=> stay_high_s)
      else $error("acknowledge did not release line");

   ack_clear_a: assert property (
      r_q.st == PMI_HOLD && wr_sup_flags
      |=> r_q.flag1 == ($past(r_q.flag1) & $past(reg_wdata_i)))
      else $error("supply flag write not an and");

   no_ack_hold_a: assert property (
      r_q.st == PMI_HOLD && !ack_hit |=> !irq_n_o)
      else $error("line released without acknowledge");

   flag_cause_a: assert property (
      r_q.st == PMI_IDLE ##1 r_q.st == PMI_LATCH
      |-> (r_q.flag1 & $past(r_q.mask1)) == 8'h00 &&
          (r_q.flag2 & $past(r_q.mask2)) == 8'h00)
      else $error("flag set for masked source");

   evt_flag_ro_a: assert property (
      r_q.st == PMI_HOLD && wr_evt_flags
      |=> (r_q.flag2 & ~$past(r_q.flag2)) == 8'h00)
      else $error("event flag set by host write");

endmodule // pmi_irq_ctrl

// ---- testbench/pmi_host_model.sv ----
// Purpose: host side model that drives the register port
// Assumes: strobes are one-cycle pulses launched at a falling edge
// Notes:   aborted transfers never reach the port, so none are modelled
`timescale 1ns/100ps
module pmi_host_model
   import pmi_pkg::*;
(
   // clock
   input  wire logic       clk_i,
   // register port
   output logic      [7:0] reg_addr_o,
   output logic      [7:0] reg_wdata_o,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   input  wire logic [7:0] reg_rdata_i
);
   initial
   begin
      reg_addr_o  = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
   end
   // released lines show inverted values, not the last ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_addr_o  = a;
      reg_wdata_o = d;
      reg_wr_o    = 1'b1;
      @(negedge clk_i);
      reg_wr_o    = 1'b0;
      reg_addr_o  = ~a;
      reg_wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_rd_o   = 1'b1;
      @(negedge clk_i);
      reg_rd_o   = 1'b0;
      reg_addr_o = ~a;
      d          = reg_rdata_i;
   endtask
endmodule // pmi_host_model

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench of the interrupt mask and flag block
// Assumes: status inputs change at falling edges
// Notes:   every source bit is tried alone through its mask
`timescale 1ns/100ps
module tb_top
   import pmi_pkg::*;
;
   // starts low without an edge, so no false negedge at time zero
   logic       clk_i = 1'b0;
   logic       rstn_i;
   logic [7:0] supply_fault_i;
   logic [7:0] event_status_i;
   logic [7:0] reg_addr_i;
   logic [7:0] reg_wdata_i;
   logic       reg_wr_i;
   logic       reg_rd_i;
   logic [7:0] reg_rdata_o;
   logic       irq_n_o;
   logic [7:0] rd_val;
   logic [7:0] bit_v;
   logic [7:0] ack_a;
   int         fail_count;
   int         checks_done;

   pmi_irq_ctrl u_pmi_irq_ctrl (.clk_i, .rstn_i, .supply_fault_i,
      .event_status_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .irq_n_o);
   pmi_host_model u_pmi_host_model (.clk_i, .reg_addr_o(reg_addr_i),
      .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
      .reg_rdata_i(reg_rdata_o));

   initial
   begin
      forever #20 clk_i = ~clk_i;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      u_pmi_host_model.rd(a, rd_val);
      check(rd_val, exp);
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // a hang is cut short and counted
   initial
   begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      end_sim();
   end
   initial
   begin
      fail_count     = 0;
      checks_done    = 0;
      rstn_i         = 1'b0;
      supply_fault_i = 8'h00;
      event_status_i = 8'h00;
      step(2);
      rstn_i = 1'b1;
      check({7'h00, irq_n_o}, 8'h01);
      rd_chk(PMI_SUPPLY_MASK_ADDR, 8'h00);
      rd_chk(PMI_EVENT_MASK_ADDR, 8'h00);
      rd_chk(PMI_SUPPLY_FLAGS_ADDR, 8'h00);
      rd_chk(PMI_EVENT_FLAGS_ADDR, 8'h00);
      rd_chk(8'h07, 8'h00);
      u_pmi_host_model.wr(PMI_SUPPLY_MASK_ADDR, 8'ha5);
      rd_chk(PMI_SUPPLY_MASK_ADDR, 8'ha5);
      u_pmi_host_model.wr(PMI_EVENT_MASK_ADDR, 8'h5a);
      rd_chk(PMI_EVENT_MASK_ADDR, 8'h5a);
      u_pmi_host_model.wr(PMI_EVENT_FLAGS_ADDR, 8'hff);
      rd_chk(PMI_EVENT_FLAGS_ADDR, 8'h00);
      for (int j = 0; j < 2; j++)
         for (int i = 0; i < 8; i++)
         begin
            bit_v = 8'h01 << i;
            ack_a = j ? PMI_EVENT_FLAGS_ADDR : PMI_SUPPLY_FLAGS_ADDR;
            // only bit i open, all eight sources toggle
            u_pmi_host_model.wr(j ? PMI_EVENT_MASK_ADDR
               : PMI_SUPPLY_MASK_ADDR, ~bit_v);
            if (j) event_status_i = ~event_status_i;
            else supply_fault_i = ~supply_fault_i;
            // flags land one edge before the line drops
            step(1);
            check({7'h00, irq_n_o}, 8'h01);
            step(1);
            check({7'h00, irq_n_o}, 8'h00);
            rd_chk(ack_a, bit_v);
            if (j) event_status_i = ~event_status_i;
            else supply_fault_i = ~supply_fault_i;
            step(3);
            rd_chk(ack_a, bit_v);
            u_pmi_host_model.wr(ack_a, 8'hff);
            step(1);
            check({7'h00, irq_n_o}, 8'h00);
            u_pmi_host_model.wr(ack_a, 8'h00);
            step(1);
            check({7'h00, irq_n_o}, 8'h01);
            rd_chk(ack_a, 8'h00);
            step(3);
            check({7'h00, irq_n_o}, 8'h01);
         end
      u_pmi_host_model.wr(PMI_EVENT_MASK_ADDR, 8'hff);
      event_status_i = ~event_status_i;
      step(4);
      check({7'h00, irq_n_o}, 8'h01);
      end_sim();
   end
endmodule // tb_top
